//--- rtl/dbgts_trigger_select.v
// Trigger selection logic of an on-chip debug module: control register,
// mode decode, force/tag qualification, A-then-B sequencing and interrupt.
// Assumes comparators, opcode tracker and arm flag run on clk_in, so their
// outputs are used without synchronisers.
`timescale 1ns/10ps
`include "dbgts_map.vh"

module dbgts_trigger_select (
    input  wire       clk_in,
    input  wire       nrst_in,
    input  wire [7:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       wr_in,
    input  wire       rd_in,
    output reg  [7:0] rdata_out,
    input  wire       arm_in,
    input  wire       access_in,
    input  wire       addr_eq_a_in,
    input  wire       addr_eq_b_in,
    input  wire       data_eq_b_in,
    input  wire       addr_lt_a_in,
    input  wire       addr_gt_b_in,
    input  wire       exec_a_in,
    input  wire       exec_b_in,
    output reg        tag_a_out,
    output reg        tag_b_out,
    output reg        trigger_out,
    output reg        store_out,
    output reg        begin_trace_out,
    output reg        irq_out
);

    // ============================================================
    // State codes
    localparam [1:0] S_IDLE    = 2'h0;
    localparam [1:0] S_WAIT_A  = 2'h1;
    localparam [1:0] S_AFTER_A = 2'h2;
    localparam [1:0] S_DONE    = 2'h3;

    // ============================================================
    // Reset release
    reg        rst_meta_r;
    reg        rst_sync_r;

    // The release is retimed so every flop leaves reset on the same edge.
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire       rst_n = rst_sync_r;

    // ============================================================
    // Declarations
    reg  [7:0]                 ctrl_r;
    reg  [`DBGTS_IRQ_W-1:0]    status_r;
    reg  [`DBGTS_IRQ_W-1:0]    status_nxt;
    reg  [`DBGTS_IRQ_W-1:0]    mask_r;
    reg  [1:0]                 state_r;
    reg  [1:0]                 state_nxt;
    reg                        fire_nxt;
    reg                        store_nxt;
    reg  [7:0]                 rdata_nxt;

    wire       qsel     = ctrl_r[`DBGTS_QSEL_BIT];
    wire       begin_b  = ctrl_r[`DBGTS_BEGIN_BIT];
    wire [3:0] mode     = ctrl_r[`DBGTS_MODE_HI:`DBGTS_MODE_LO];

    wire       wr_ctrl  = wr_in && (addr_in == `DBGTS_OFS_TRIG_CTRL);
    wire       wr_mask  = wr_in && (addr_in == `DBGTS_OFS_IRQ_MASK);
    wire       rd_stat  = rd_in && (addr_in == `DBGTS_OFS_IRQ_STATUS);
    wire       refused  = wr_ctrl && arm_in;

    // ============================================================
    // Mode decode helpers

    // Event-only modes store on each B event instead of ending a run.
    function is_event_only;
        input [3:0] m;
        begin
            is_event_only = (m == `DBGTS_MODE_EV_B) || (m == `DBGTS_MODE_A_EV_B);
        end
    endfunction

    // Condition carried on the A channel for each mode.
    function chan_a_hit;
        input [3:0] m;
        input       eq_a;
        input       d_b;
        input       lt_a;
        input       gt_b;
        begin
            case (m)
                `DBGTS_MODE_A_ONLY,
                `DBGTS_MODE_A_OR_B,
                `DBGTS_MODE_A_THEN_B,
                `DBGTS_MODE_A_EV_B:   chan_a_hit = eq_a;
                `DBGTS_MODE_A_AND_D:  chan_a_hit = eq_a & d_b;
                `DBGTS_MODE_A_NAND_D: chan_a_hit = eq_a & ~d_b;
                `DBGTS_MODE_INSIDE:   chan_a_hit = ~lt_a & ~gt_b;
                `DBGTS_MODE_OUTSIDE:  chan_a_hit = lt_a | gt_b;
                default:              chan_a_hit = 1'b0;
            endcase
        end
    endfunction

    // Condition carried on the B channel for each mode.
    function chan_b_hit;
        input [3:0] m;
        input       eq_b;
        begin
            case (m)
                `DBGTS_MODE_A_OR_B,
                `DBGTS_MODE_A_THEN_B: chan_b_hit = eq_b;
                `DBGTS_MODE_EV_B,
                `DBGTS_MODE_A_EV_B:   chan_b_hit = eq_b;
                default:              chan_b_hit = 1'b0;
            endcase
        end
    endfunction

    // ============================================================
    // Force or tag qualification
    wire raw_a = access_in && chan_a_hit(mode, addr_eq_a_in, data_eq_b_in,
                                         addr_lt_a_in, addr_gt_b_in);
    wire raw_b = access_in && chan_b_hit(mode, addr_eq_b_in);

    // Only mode codes up to OUTSIDE may act on an A tracker answer, so a
    // stray execution report can never fire one of the silent codes.
    wire a_live = (mode <= `DBGTS_MODE_OUTSIDE);

    // In tag mode the tracker answers only once the tagged opcode executes.
    wire ev_a  = qsel ? (exec_a_in && a_live) : raw_a;
    wire ev_b  = qsel ? exec_b_in : raw_b;

    // Tags are requested only in armed runs, so a disarmed tracker stays quiet.
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tag_a_out <= 1'b0;
            tag_b_out <= 1'b0;
        end else begin
            tag_a_out <= qsel && arm_in && raw_a;
            tag_b_out <= qsel && arm_in && raw_b;
        end
    end

    // ============================================================
    // Run sequencer
    // A run opens one cycle after the arm flag rises and ends when it falls;
    // events seen in the opening cycle are not counted.
    always @* begin
        state_nxt = state_r;
        fire_nxt  = 1'b0;
        store_nxt = 1'b0;
        if (!arm_in) begin
            state_nxt = S_IDLE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    state_nxt = S_WAIT_A;
                end
                S_WAIT_A: begin
                    case (mode)
                        `DBGTS_MODE_A_THEN_B,
                        `DBGTS_MODE_A_EV_B: begin
                            if (ev_a) begin
                                state_nxt = S_AFTER_A;
                            end
                        end
                        `DBGTS_MODE_EV_B: begin
                            store_nxt = ev_b;
                        end
                        `DBGTS_MODE_A_OR_B: begin
                            if (ev_a || ev_b) begin
                                fire_nxt  = 1'b1;
                                state_nxt = S_DONE;
                            end
                        end
                        default: begin
                            if (ev_a) begin
                                fire_nxt  = 1'b1;
                                state_nxt = S_DONE;
                            end
                        end
                    endcase
                end
                S_AFTER_A: begin
                    // B must come after A, never in the same cycle as A.
                    if (mode == `DBGTS_MODE_A_EV_B) begin
                        store_nxt = ev_b;
                    end else if (ev_b) begin
                        fire_nxt  = 1'b1;
                        state_nxt = S_DONE;
                    end
                end
                S_DONE: begin
                    state_nxt = S_DONE;
                end
                default: begin
                    state_nxt = S_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= S_IDLE;
            trigger_out <= 1'b0;
            store_out   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            trigger_out <= fire_nxt;
            store_out   <= store_nxt;
        end
    end

    // Capture direction for the FIFO logic, registered to keep it glitch free.
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            begin_trace_out <= 1'b0;
        end else begin
            begin_trace_out <= is_event_only(mode) ? 1'b1 : begin_b;
        end
    end

    // ============================================================
    // Register file
    // A refused write only raises its status flag; the control fields and
    // the run in progress are left exactly as they were.
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `DBGTS_CTRL_RESET;
            mask_r <= `DBGTS_MASK_RESET;
        end else begin
            if (wr_ctrl && !arm_in) begin
                ctrl_r <= wdata_in & `DBGTS_CTRL_WMASK;
            end
            if (wr_mask) begin
                mask_r <= wdata_in[`DBGTS_IRQ_W-1:0];
            end
        end
    end

    // Read clears the status, but an event in the same cycle survives.
    always @* begin
        status_nxt = rd_stat ? {`DBGTS_IRQ_W{1'b0}} : status_r;
        if (fire_nxt) begin
            status_nxt[`DBGTS_IRQ_TRIG_BIT] = 1'b1;
        end
        if (store_nxt) begin
            status_nxt[`DBGTS_IRQ_STORE_BIT] = 1'b1;
        end
        if (refused) begin
            status_nxt[`DBGTS_IRQ_REFUSE_BIT] = 1'b1;
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= {`DBGTS_IRQ_W{1'b0}};
            irq_out  <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_out  <= |(status_nxt & mask_r);
        end
    end

    // Read mux; unmapped addresses answer zero.
    always @* begin
        rdata_nxt = 8'h00;
        case (addr_in)
            `DBGTS_OFS_TRIG_CTRL:  rdata_nxt = ctrl_r;
            `DBGTS_OFS_IRQ_STATUS: rdata_nxt = {5'h00, status_r};
            `DBGTS_OFS_IRQ_MASK:   rdata_nxt = {5'h00, mask_r};
            `DBGTS_OFS_RUN_STATE:  rdata_nxt = {5'h00, arm_in, state_r};
            default:               rdata_nxt = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_in ? rdata_nxt : 8'h00;
        end
    end

endmodule

//--- rtl/dbgts_map.vh
// Register map, field positions, reset values and encodings of the
// debug trigger selection block.
// Assumes an 8-bit register port with byte-wide registers, one per address.
`ifndef DBGTS_MAP_VH
`define DBGTS_MAP_VH

// ============================================================
// Register addresses
`define DBGTS_ADDR_W          8
`define DBGTS_OFS_TRIG_CTRL   8'h00
`define DBGTS_OFS_IRQ_STATUS  8'h01
`define DBGTS_OFS_IRQ_MASK    8'h02
`define DBGTS_OFS_RUN_STATE   8'h03

// ============================================================
// Trigger control fields
`define DBGTS_QSEL_BIT        7
`define DBGTS_BEGIN_BIT       6
`define DBGTS_MODE_HI         3
`define DBGTS_MODE_LO         0
`define DBGTS_CTRL_WMASK      8'hCF
`define DBGTS_CTRL_RESET      8'h00

// ============================================================
// Trigger mode codes
`define DBGTS_MODE_A_ONLY     4'h0
`define DBGTS_MODE_A_OR_B     4'h1
`define DBGTS_MODE_A_THEN_B   4'h2
`define DBGTS_MODE_EV_B       4'h3
`define DBGTS_MODE_A_EV_B     4'h4
`define DBGTS_MODE_A_AND_D    4'h5
`define DBGTS_MODE_A_NAND_D   4'h6
`define DBGTS_MODE_INSIDE     4'h7
`define DBGTS_MODE_OUTSIDE    4'h8

// ============================================================
// Interrupt status and mask bits
`define DBGTS_IRQ_TRIG_BIT    0
`define DBGTS_IRQ_STORE_BIT   1
`define DBGTS_IRQ_REFUSE_BIT  2
`define DBGTS_IRQ_W           3
`define DBGTS_MASK_RESET      3'h0

`endif

//--- dv/dbgts_tracker_model.sv
// Behavioural opcode tracker that answers tag requests from the block.
// Assumes requests are one-cycle pulses on the block's clock.
`timescale 1ns/10ps
module dbgts_tracker_model (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic tag_a_in,
    input  wire logic tag_b_in,
    input  wire logic exec_en_in,
    input  wire logic slow_in,
    output wire logic exec_a_out,
    output wire logic exec_b_out
);
    // ============================================================
    // Answer path
    // The tagged opcode only executes when the bench says so; slow adds a cycle.
    logic [1:0] pa_r;
    logic [1:0] pb_r;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pa_r <= 2'b00;
            pb_r <= 2'b00;
        end else begin
            pa_r <= {pa_r[0], tag_a_in & exec_en_in};
            pb_r <= {pb_r[0], tag_b_in & exec_en_in};
        end
    end
    assign exec_a_out = slow_in ? pa_r[1] : pa_r[0];
    assign exec_b_out = slow_in ? pb_r[1] : pb_r[0];
endmodule

//--- dv/dbgts_trigger_select_monitor.sv
// Concurrent checks on the ports of the trigger select block.
// Assumes one clock; the control register is mirrored from bus writes.
`timescale 1ns/10ps
module dbgts_trigger_select_monitor (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       arm_in,
    input wire logic       access_in,
    input wire logic       addr_eq_b_in,
    input wire logic       addr_eq_a_in,
    input wire logic       exec_a_in,
    input wire logic       exec_b_in,
    input wire logic       tag_a_out,
    input wire logic       trigger_out,
    input wire logic       store_out,
    input wire logic       begin_trace_out
);
    // ============================================================
    // Mirror of the control register
    // A write while armed is dropped, so the mirror never drifts from the block.
    logic [7:0] sh_r;
    wire  [3:0] m        = sh_r[3:0];
    wire        ev_only  = (m == 4'h3) || (m == 4'h4);
    wire        bt_exp   = ev_only || sh_r[6];
    wire        hit_a    = access_in && addr_eq_a_in;
    wire        hit_b    = access_in && addr_eq_b_in;
    wire        exec_any = exec_a_in || exec_b_in;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sh_r <= 8'h00;
        end else if (wr_in && addr_in == 8'h00 && !arm_in) begin
            sh_r <= wdata_in & 8'hCF;
        end
    end
    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_ctrl_readback: assert property (rd_in && addr_in == 8'h00 |=> rdata_out == $past(sh_r))
        else $error("control readback wrong");
    a_fixed_zero: assert property (rd_in && addr_in == 8'h00 |=> rdata_out[5:4] == 2'b00)
        else $error("control bits 5:4 not zero");
    a_high_mute: assert property (m > 4'h8 |-> !trigger_out && !store_out)
        else $error("event in a silent mode");
    a_store_modes: assert property (store_out |-> ev_only)
        else $error("store outside event-only modes");
    a_trig_modes: assert property (trigger_out |-> !ev_only)
        else $error("trigger in event-only mode");
    a_begin_sel: assert property (begin_trace_out == $past(bt_exp))
        else $error("begin trace level wrong");
    a_force_cause: assert property (trigger_out && !sh_r[7] && m == 4'h0 |-> $past(hit_a))
        else $error("force trigger without A hit");
    a_a_then_b: assert property (arm_in && !sh_r[7] && m == 4'h2 && !hit_b |=> !trigger_out)
        else $error("sequence trigger without B hit");
    a_tag_cause: assert property (trigger_out && sh_r[7] |-> $past(exec_any))
        else $error("tag trigger without execution");
    // A tag-mode hit on A is a two-step affair: the hit, then the request.
    sequence s_tag_hit;
        arm_in && sh_r[7] && m == 4'h0 && hit_a;
    endsequence
    sequence s_tag_ask;
        tag_a_out;
    endsequence
    a_tag_request: assert property (s_tag_hit |=> s_tag_ask)
        else $error("no tag request after an A hit in tag mode");
endmodule

//--- dv/tb_debug_trigger_select.sv
// Self-checking bench for the trigger select block and a tracker model.
// Assumes the design and the checker compile first; the checker is bound below.
`timescale 1ns/10ps
module tb_debug_trigger_select;
    // ============================================================
    // Stimulus and observation
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        arm_in = 1'b0;
    logic        access_in = 1'b0;
    logic [4:0]  cmp_r = 5'h00;
    logic        exe_en = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  rdata_out;
    logic        exec_a_in, exec_b_in, tag_a_out, tag_b_out;
    logic        trigger_out, store_out, begin_trace_out, irq_out;
    int          n_fail = 0;
    int          total_checks = 0;
    logic [20:0] rows [18];
    always #10 clk_in = ~clk_in;
    // The design's comparator flags come from cmp_r: eq_a, eq_b, data_b, below_a, above_b.
    dbgts_trigger_select dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .arm_in(arm_in), .access_in(access_in), .addr_eq_a_in(cmp_r[4]),
        .addr_eq_b_in(cmp_r[3]), .data_eq_b_in(cmp_r[2]), .addr_lt_a_in(cmp_r[1]),
        .addr_gt_b_in(cmp_r[0]), .exec_a_in(exec_a_in), .exec_b_in(exec_b_in),
        .tag_a_out(tag_a_out), .tag_b_out(tag_b_out), .trigger_out(trigger_out),
        .store_out(store_out), .begin_trace_out(begin_trace_out), .irq_out(irq_out));
    dbgts_tracker_model u_trk (.clk_in(clk_in), .nrst_in(nrst_in), .tag_a_in(tag_a_out),
        .tag_b_in(tag_b_out), .exec_en_in(exe_en), .slow_in(slow),
        .exec_a_out(exec_a_in), .exec_b_out(exec_b_in));
    task automatic report_and_stop;
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus cycles: strobes last one cycle; read data are looked at in the cycle after.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    // One armed run: row is control, two comparator cycles, execute, trigger, store.
    task automatic run(input logic [20:0] r);
        logic st, sg, bt;
        st = 1'b0;
        sg = 1'b0;
        bt = (r[16:13] == 4'h3) || (r[16:13] == 4'h4) || r[19];
        exe_en <= r[2];
        wr(8'h00, r[20:13]);
        @(posedge clk_in);
        arm_in <= 1'b1;
        #1 chk({7'h00, begin_trace_out}, {7'h00, bt});
        fork
            begin
                @(posedge clk_in);
                access_in <= 1'b1;
                cmp_r <= r[12:8];
                @(posedge clk_in);
                cmp_r <= r[7:3];
                @(posedge clk_in);
                access_in <= 1'b0;
                cmp_r <= 5'h00;
            end
            repeat (10) begin
                @(posedge clk_in);
                st = st | trigger_out;
                sg = sg | store_out;
            end
        join
        arm_in <= 1'b0;
        chk({6'h00, st, sg}, {6'h00, r[1:0]});
        repeat (2) @(posedge clk_in);
    endtask
    // A hang is cut short well beyond the length of the sequence.
    initial begin
        #100000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        rows = '{{8'h00,5'h10,5'h00,3'b010}, {8'h40,5'h08,5'h00,3'b000}, {8'h01,5'h08,5'h00,3'b010},
            {8'h02,5'h18,5'h00,3'b000}, {8'h42,5'h10,5'h08,3'b010}, {8'h03,5'h08,5'h00,3'b001},
            {8'h04,5'h08,5'h00,3'b000}, {8'h04,5'h10,5'h08,3'b001}, {8'h05,5'h14,5'h00,3'b010},
            {8'h05,5'h10,5'h00,3'b000}, {8'h06,5'h10,5'h00,3'b010}, {8'h06,5'h14,5'h00,3'b000},
            {8'h07,5'h10,5'h10,3'b010}, {8'h07,5'h02,5'h01,3'b000}, {8'h08,5'h02,5'h00,3'b010},
            {8'h08,5'h10,5'h08,3'b000}, {8'h80,5'h10,5'h00,3'b110}, {8'h80,5'h10,5'h00,3'b000}};
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        for (int a = 0; a < 3; a++) rd(a[7:0], 8'h00);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'hCF);
        foreach (rows[i]) run(rows[i]);
        for (int m = 9; m < 16; m++) run({4'h0, m[3:0], 10'h3FF, 3'b000});
        slow <= 1'b1;
        run(rows[16]);
        rd(8'h01, 8'h03);
        rd(8'h01, 8'h00);
        wr(8'h02, 8'h04);
        @(posedge clk_in);
        arm_in <= 1'b1;
        wr(8'h00, 8'h41);
        #1 chk({7'h00, irq_out}, 8'h01);
        rd(8'h00, 8'h80);
        rd(8'h03, 8'h05);
        rd(8'h01, 8'h04);
        chk({7'h00, irq_out}, 8'h00);
        rd(8'h10, 8'h00);
        @(posedge clk_in);
        arm_in <= 1'b0;
        run(rows[0]);
        chk({7'h00, irq_out}, 8'h00);
        rd(8'h01, 8'h01);
        wr(8'h02, 8'h01);
        run(rows[0]);
        chk({7'h00, irq_out}, 8'h01);
        rd(8'h01, 8'h01);
        chk({7'h00, irq_out}, 8'h00);
        // A second reset while disarmed must bring control and mask back to zero.
        wr(8'h00, 8'hC7);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(8'h00, 8'h00);
        rd(8'h02, 8'h00);
        chk({7'h00, begin_trace_out}, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        report_and_stop;
    end
endmodule
bind dbgts_trigger_select dbgts_trigger_select_monitor u_mon (.clk_in, .nrst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .arm_in, .access_in, .addr_eq_b_in, .addr_eq_a_in,
    .exec_a_in, .exec_b_in, .tag_a_out, .trigger_out, .store_out, .begin_trace_out);
